// File: common/asb_pkg.sv
// Purpose: shared constants and carriers for the sample buffer control block
// Assumes: APB with 32-bit data, one register per aligned word (index * 4)
// Notes:   register indices are byte-register numbers; bus address is index << 2
package asb_pkg;

    // ------------------------------------------------------------------
    // register indices and bus geometry
    // ------------------------------------------------------------------
    localparam int          APB_AW            = 12;
    localparam logic [7:0]  IDX_THRESHOLD     = 8'h5e;
    localparam logic [7:0]  IDX_OP_CONTROL    = 8'h5f;
    localparam logic [7:0]  IDX_LEVEL_LOW     = 8'h60;
    localparam logic [7:0]  IDX_LEVEL_HIGH    = 8'h61;
    localparam logic [7:0]  IDX_CLEAR         = 8'h62;
    localparam logic [7:0]  IDX_READ          = 8'h63;
    localparam logic [7:0]  IDX_DEV_CONTROL   = 8'h80;
    localparam logic [7:0]  IDX_IRQ_SRC_TWO   = 8'h81;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          BIT_BUF_ACTIVE    = 7;
    localparam int          BIT_RES_SELECT    = 6;
    localparam int          BIT_FULL_IRQ_EN   = 5;
    localparam int          BIT_TRIGGER_INPUT_EVENT_SEEN     = 7;
    localparam int          BIT_OPER_ENABLE   = 0;
    localparam int          BIT_FULL_FLAG     = 6;
    localparam int          BIT_WMARK_FLAG    = 5;
    localparam logic [7:0]  RST_THRESHOLD     = 8'h00;
    localparam logic [7:0]  RST_OP_CONTROL    = 8'h00;
    localparam logic        RST_OPER_ENABLE   = 1'b0;

    // ------------------------------------------------------------------
    // storage geometry, in bytes
    // ------------------------------------------------------------------
    localparam int          BUF_DEPTH         = 516;
    localparam logic [10:0] CAP_HI_RES        = 11'h204;  // 86 sets of 6 bytes
    localparam logic [10:0] CAP_LO_RES        = 11'h201;  // 171 sets of 3 bytes
    localparam logic [10:0] SET_BYTES_HI      = 11'h006;
    localparam logic [10:0] SET_BYTES_LO      = 11'h003;

    // ------------------------------------------------------------------
    // timing: level may lag a buffer read by at most this much
    // ------------------------------------------------------------------
    localparam int          CLK_HZ            = 25_000_000;
    localparam int          LEVEL_LAG_NS      = 1000;
    localparam int          LEVEL_LAG_CYC     = (LEVEL_LAG_NS * (CLK_HZ / 1_000_000)) / 1000;

    // ------------------------------------------------------------------
    // modes and trigger phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_FIFO    = 2'h0,
        MODE_STREAM  = 2'h1,
        MODE_TRIGGER = 2'h2,
        MODE_NONE    = 2'h3
    } asb_mode_e;

    typedef enum logic [1:0] {
        TP_PRE  = 2'h0,
        TP_POST = 2'h1,
        TP_DONE = 2'h3
    } asb_trigger_input_event_phase_e;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } asb_apb_req_s;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } asb_sample_s;

    typedef struct packed {
        logic freefall_event;
        logic tap_status_high;
        logic tap_status_low;
        logic wakeup_event;
        logic tilt_event;
        logic trigger_input_event;
    } asb_events_s;

endpackage

// File: design/asb_buffer_ctrl.sv
// Purpose: control, status and storage of the accelerometer sample buffer
// Assumes: samples and motion events come from logic on i_ref_clk
// Notes:   one byte leaves the buffer per APB read of the read register
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module asb_buffer_ctrl
    import asb_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
)
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire asb_apb_req_s i_apb,
    output logic [31:0]       o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    input  wire logic         i_sample_valid,
    input  wire asb_sample_s  i_sample,
    input  wire asb_events_s  i_events,
    output logic [9:0]        o_fill_byte_count,
    output logic              o_trigger_seen,
    output logic              o_operating_enable,
    output logic              o_buffer_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]      thr_q;
    logic [7:0]      ctl_q;
    logic            op_en_q;
    logic [10:0]     count_q;
    logic [10:0]     count_d;
    logic [9:0]      wr_ptr_q;
    logic [9:0]      rd_ptr_q;
    logic            trigger_input_event_seen_q;
    logic            full_flag_q;
    logic            wmark_flag_q;
    logic [31:0]     rdata_q;
    logic            slverr_q;
    asb_trigger_input_event_phase_e phase_q;
    logic [7:0]      mem [DEPTH];

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    logic            buf_active;
    logic            res16;
    logic            full_irq_en;
    asb_mode_e       mode;
    logic [10:0]     set_bytes;
    logic [10:0]     cap_bytes;
    logic [10:0]     thr_bytes;
    logic            collecting;
    logic            trigger_evt;

    assign buf_active  = ctl_q[BIT_BUF_ACTIVE];
    assign res16       = ctl_q[BIT_RES_SELECT];
    assign full_irq_en = ctl_q[BIT_FULL_IRQ_EN];
    assign mode        = asb_mode_e'(ctl_q[1:0]);
    assign set_bytes   = res16 ? SET_BYTES_HI : SET_BYTES_LO;
    assign cap_bytes   = res16 ? CAP_HI_RES : CAP_LO_RES;
    assign collecting  = buf_active && op_en_q;
    // a trigger is any motion engine event
    assign trigger_evt = |i_events;

    // threshold in bytes: samples times set size, at most 255 * 6
    always_comb
    begin
        thr_bytes = 11'((res16 ? 13'(thr_q) * 13'd6 : 13'(thr_q) * 13'd3));
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic [7:0]      idx;
    logic            word_ok;
    logic            mapped;
    logic            acc;
    logic            wr_acc;
    logic            rd_acc;
    logic            setup;

    assign idx     = i_apb.paddr[9:2];
    assign word_ok = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[APB_AW-1:10] == '0);
    assign setup   = i_apb.psel && !i_apb.penable;
    assign acc     = i_apb.psel && i_apb.penable;
    assign wr_acc  = acc && i_apb.pwrite;
    assign rd_acc  = acc && !i_apb.pwrite;

    always_comb
    begin
        case (idx)
            IDX_THRESHOLD, IDX_OP_CONTROL, IDX_LEVEL_LOW, IDX_LEVEL_HIGH,
            IDX_CLEAR, IDX_READ, IDX_DEV_CONTROL, IDX_IRQ_SRC_TWO:
                mapped = word_ok;
            default:
                mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // flush sources: any one of them empties the buffer next edge
    // ------------------------------------------------------------------
    logic            clear_wr;
    logic            flush;
    logic            pop;

    assign clear_wr = wr_acc && mapped && (idx == IDX_CLEAR);
    // falling edge of buffer-active or of operating enable empties it
    assign flush    = clear_wr
                    || (wr_acc && mapped && idx == IDX_OP_CONTROL
                        && ctl_q[BIT_BUF_ACTIVE] && !i_apb.pwdata[BIT_BUF_ACTIVE])
                    || (wr_acc && mapped && idx == IDX_DEV_CONTROL
                        && op_en_q && !i_apb.pwdata[BIT_OPER_ENABLE]);
    // an empty buffer answers zero and does not move
    assign pop      = rd_acc && mapped && (idx == IDX_READ) && (count_q != 11'h000);

    // ------------------------------------------------------------------
    // push / drop decision for an arriving sample set
    // ------------------------------------------------------------------
    logic            room;
    logic            push;
    logic [10:0]     drop_bytes;
    logic [10:0]     avail;

    assign avail = count_q - (pop ? 11'h001 : 11'h000);
    assign room  = (avail + set_bytes) <= cap_bytes;

    always_comb
    begin
        push       = 1'b0;
        drop_bytes = 11'h000;
        if (collecting && i_sample_valid && !flush)
        begin
            case (mode)
                MODE_FIFO:
                begin
                    push = room;
                end
                MODE_STREAM:
                begin
                    push = 1'b1;
                    if (!room)
                    begin
                        drop_bytes = set_bytes;
                    end
                end
                MODE_TRIGGER:
                begin
                    if (phase_q == TP_PRE)
                    begin
                        push = 1'b1;
                        // keep only the pre-trigger window
                        if (!room || avail >= thr_bytes)
                        begin
                            drop_bytes = (avail >= set_bytes) ? set_bytes : avail;
                        end
                    end
                    else if (phase_q == TP_POST)
                    begin
                        push = room;
                    end
                end
                default:
                begin
                    push = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pointer arithmetic modulo depth
    // ------------------------------------------------------------------
    function automatic logic [9:0] wrap(input logic [9:0] p, input logic [10:0] inc);
        logic [11:0] s;
        s = 12'(p) + 12'(inc);
        if (s >= 12'(DEPTH))
        begin
            s = s - 12'(DEPTH);
        end
        return s[9:0];
    endfunction

    // sample bytes in buffer order: axis by axis, low byte first at high resolution, high byte only at low resolution
    logic [7:0]      set_byte [6];

    always_comb
    begin
        if (res16)
        begin
            set_byte[0] = i_sample.x[7:0];
            set_byte[1] = i_sample.x[15:8];
            set_byte[2] = i_sample.y[7:0];
            set_byte[3] = i_sample.y[15:8];
            set_byte[4] = i_sample.z[7:0];
            set_byte[5] = i_sample.z[15:8];
        end
        else
        begin
            set_byte[0] = i_sample.x[15:8];
            set_byte[1] = i_sample.y[15:8];
            set_byte[2] = i_sample.z[15:8];
            set_byte[3] = 8'h00;
            set_byte[4] = 8'h00;
            set_byte[5] = 8'h00;
        end
    end

    // storage write: a whole set lands in one edge
    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            for (int j = 0; j < 6; j++)
            begin
                if (11'(j) < set_bytes)
                begin
                    mem[wrap(wr_ptr_q, 11'(j))] <= set_byte[j];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // pointers and byte count
    // ------------------------------------------------------------------
    always_comb
    begin
        count_d = count_q + (push ? set_bytes : 11'h000) - drop_bytes
                - (pop ? 11'h001 : 11'h000);
    end

    // level follows a read on the very next edge, well inside the lag
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || flush)
        begin
            count_q  <= 11'h000;
            wr_ptr_q <= 10'h000;
            rd_ptr_q <= 10'h000;
        end
        else
        begin
            count_q  <= count_d;
            if (push)
            begin
                wr_ptr_q <= wrap(wr_ptr_q, set_bytes);
            end
            rd_ptr_q <= wrap(rd_ptr_q, drop_bytes + (pop ? 11'h001 : 11'h000));
        end
    end

    // ------------------------------------------------------------------
    // trigger phase tracking
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || flush)
        begin
            phase_q <= TP_PRE;
        end
        else
        begin
            case (phase_q)
                TP_PRE:
                begin
                    if (collecting && mode == MODE_TRIGGER && trigger_evt)
                    begin
                        phase_q <= TP_POST;
                    end
                end
                TP_POST:
                begin
                    // once full, only a clear or restart re-arms it
                    if (!room && i_sample_valid)
                    begin
                        phase_q <= TP_DONE;
                    end
                end
                TP_DONE:
                begin
                    phase_q <= TP_DONE;
                end
                default:
                begin
                    phase_q <= TP_PRE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // sticky flags: a set in the clearing cycle wins
    // ------------------------------------------------------------------
    logic            wmark_set;
    logic            full_set;
    logic            trigger_input_event_set;
    logic [10:0]     count_nx;

    // level as it stands after this edge: a flush leaves no stale level to re-set a flag
    assign count_nx  = flush ? 11'h000 : count_d;
    assign wmark_set = collecting && (mode == MODE_FIFO || mode == MODE_STREAM)
                     && (thr_q != 8'h00) && (count_nx >= thr_bytes);
    assign full_set  = collecting && full_irq_en
                     && (count_nx + set_bytes > cap_bytes);
    assign trigger_input_event_set  = collecting && (mode == MODE_TRIGGER) && (phase_q == TP_PRE)
                     && trigger_evt;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            wmark_flag_q <= 1'b0;
        end
        else if (wmark_set)
        begin
            wmark_flag_q <= 1'b1;
        end
        else if (flush)
        begin
            wmark_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            full_flag_q <= 1'b0;
        end
        else if (full_set)
        begin
            full_flag_q <= 1'b1;
        end
        else if (flush || !full_irq_en)
        begin
            full_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            trigger_input_event_seen_q <= 1'b0;
        end
        else if (trigger_input_event_set)
        begin
            trigger_input_event_seen_q <= 1'b1;
        end
        else if (flush)
        begin
            trigger_input_event_seen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control registers, writable while running
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            thr_q   <= RST_THRESHOLD;
            ctl_q   <= RST_OP_CONTROL;
            op_en_q <= RST_OPER_ENABLE;
        end
        else if (wr_acc && mapped)
        begin
            case (idx)
                IDX_THRESHOLD:   thr_q   <= i_apb.pwdata[7:0];
                // bits 4:2 read as zero
                IDX_OP_CONTROL:  ctl_q   <= {i_apb.pwdata[7:5], 3'h0,
                                             i_apb.pwdata[1:0]};
                IDX_DEV_CONTROL: op_en_q <= i_apb.pwdata[BIT_OPER_ENABLE];
                default:         op_en_q <= op_en_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read mux, sampled in the setup cycle so prdata is a flop
    // ------------------------------------------------------------------
    logic [7:0]      rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        case (idx)
            IDX_THRESHOLD:   rd_byte = thr_q;
            IDX_OP_CONTROL:  rd_byte = ctl_q;
            IDX_LEVEL_LOW:   rd_byte = count_q[7:0];
            IDX_LEVEL_HIGH:  rd_byte = {trigger_input_event_seen_q, 5'h00, count_q[9:8]};
            IDX_READ:        rd_byte = (count_q != 11'h000) ? mem[rd_ptr_q] : 8'h00;
            IDX_DEV_CONTROL: rd_byte = {7'h00, op_en_q};
            IDX_IRQ_SRC_TWO: rd_byte = {1'b0, full_flag_q, wmark_flag_q, 5'h00};
            default:         rd_byte = 8'h00;
        endcase
    end

    // limitation: a Stream drop between setup and access can shift the head byte
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q  <= (mapped && !i_apb.pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            slverr_q <= !mapped;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_pready           = acc;
    assign o_prdata           = rdata_q;
    assign o_pslverr          = slverr_q && acc;
    assign o_fill_byte_count  = count_q[9:0];
    assign o_trigger_seen     = trigger_input_event_seen_q;
    assign o_operating_enable = op_en_q;
    assign o_buffer_irq       = full_flag_q || wmark_flag_q;

endmodule // asb_buffer_ctrl

`default_nettype wire

// File: dv/asb_buffer_ctrl_asserts.sv
// Purpose: timing checks on the sample buffer control ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   control and threshold are mirrored from APB writes
`timescale 1ns/1ps
`default_nettype none
module asb_buffer_ctrl_asserts
    import asb_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
)
(
    input wire logic         i_ref_clk,
    input wire logic         i_rst,
    input wire asb_apb_req_s i_apb,
    input wire logic         i_sample_valid,
    input wire asb_events_s  i_events,
    input wire logic [9:0]   o_fill_byte_count,
    input wire logic         o_trigger_seen,
    input wire logic         o_operating_enable,
    input wire logic         o_buffer_irq
);
    logic [7:0]  ctl_q;
    logic [7:0]  thr_q;
    logic [10:0] sb;
    logic [10:0] cap;
    logic [10:0] nx;
    logic        acc;
    logic        wr;
    logic        smp;
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    // bus phase and set geometry seen by the block
    assign acc = i_apb.psel && i_apb.penable;
    assign wr  = acc && i_apb.pwrite;
    assign sb  = ctl_q[6] ? SET_BYTES_HI : SET_BYTES_LO;
    assign cap = ctl_q[6] ? CAP_HI_RES : CAP_LO_RES;
    assign nx  = 11'(o_fill_byte_count) + sb;
    // bus idle so no pop or flush shares the edge
    assign smp = i_sample_valid && ctl_q[7] && o_operating_enable && !acc;
    // mirrors, so the checks need no internal signals
    always_ff @(posedge i_ref_clk)
        if (i_rst) ctl_q <= 8'h00;
        else if (wr && i_apb.paddr == ad(IDX_OP_CONTROL)) ctl_q <= i_apb.pwdata[7:0];
    always_ff @(posedge i_ref_clk)
        if (i_rst) thr_q <= 8'h00;
        else if (wr && i_apb.paddr == ad(IDX_THRESHOLD)) thr_q <= i_apb.pwdata[7:0];
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    AST_STEP: assert property (smp && ctl_q[1:0] == 2'h0 && nx <= cap
        |=> 11'(o_fill_byte_count) == $past(nx)) else $error("level step wrong");
    AST_FULL: assert property (smp && ctl_q[1:0] == 2'h0 && nx > cap
        |=> $stable(o_fill_byte_count)) else $error("full buffer took a set");
    AST_PRE: assert property (smp && ctl_q[1:0] == 2'h2 && !o_trigger_seen && !(|i_events)
        && thr_q >= 8'h02 && 11'(o_fill_byte_count) >= 11'(thr_q) * sb
        |=> $stable(o_fill_byte_count)) else $error("pre window grew");
    AST_TRIGGER_INPUT_EVENT: assert property (|i_events && ctl_q[1:0] == 2'h2 && ctl_q[7]
        && o_operating_enable && !acc |=> o_trigger_seen) else $error("trigger missed");
    AST_WMARK: assert property (!acc && ctl_q[1:0] < 2'h2 && thr_q != 8'h00
        && 11'(o_fill_byte_count) >= 11'(thr_q) * sb |=> o_buffer_irq)
        else $error("watermark missed");
    AST_CLR: assert property (wr && i_apb.paddr == ad(IDX_CLEAR) && !i_sample_valid
        && !(|i_events) |=> o_fill_byte_count == 10'h000 && !o_trigger_seen ##1 !o_buffer_irq)
        else $error("clear incomplete");
    AST_STBY: assert property (wr && i_apb.paddr == ad(IDX_DEV_CONTROL)
        && !i_apb.pwdata[0] && o_operating_enable && !i_sample_valid
        |=> o_fill_byte_count == 10'h000) else $error("standby kept data");
    AST_LAG: assert property (acc && !i_apb.pwrite && i_apb.paddr == ad(IDX_READ)
        && o_fill_byte_count != 10'h000 && !i_sample_valid
        |=> o_fill_byte_count == $past(o_fill_byte_count) - 10'h001) else $error("pop lag");
    COV_CLR: cover property (wr && i_apb.paddr == ad(IDX_CLEAR));
    COV_FULL: cover property (o_fill_byte_count == CAP_HI_RES[9:0]);
    COV_TRIGGER_INPUT_EVENT: cover property ($rose(o_trigger_seen));
endmodule // asb_buffer_ctrl_asserts
`default_nettype wire

// File: dv/asb_host_model.sv
// Purpose: host side APB master for the buffer registers
// Assumes: one transfer at a time, byte address is index times four
// Notes:   waits on pready without a limit; the bench watchdog ends hangs
`timescale 1ns/1ps
`default_nettype none
module asb_host_model
    import asb_pkg::*;
(
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_ref_clk,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    output var asb_apb_req_s o_apb
);
    initial o_apb = '0;
    // setup, then access held until pready; single bytes only
    task automatic xfer(input logic w, input logic [7:0] i, d, output logic [7:0] r,
                        output logic e);
        @(posedge i_ref_clk);
        o_apb <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
        @(posedge i_ref_clk);
        o_apb.penable <= 1'b1;
        do @(posedge i_ref_clk); while (i_pready !== 1'b1);
        r = i_prdata[7:0];
        e = i_pslverr;
        o_apb <= '0;
    endtask
endmodule // asb_host_model
`default_nettype wire

// File: dv/asb_buffer_ctrl_bench.sv
// Purpose: register level bench for the sample buffer control block
// Assumes: host model issues the bus cycles, bench drives samples
// Notes:   expected levels come from set sizes and capacities
`timescale 1ns/1ps
`default_nettype none
module asb_buffer_ctrl_bench
    import asb_pkg::*;
;
    logic         i_ref_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic         sv = 1'b0;
    asb_events_s  ev = '0;
    asb_sample_s  smp = '{16'ha1b2, 16'hc3d4, 16'he5f6};
    asb_apb_req_s apb;
    logic [31:0]  prd;
    logic         rdy, err, trg, oen, irq;
    logic [9:0]   lvl;
    int           n_mismatch = 0;
    int           total_checks = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    asb_buffer_ctrl dut (.i_ref_clk, .i_rst, .i_apb(apb), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .i_sample_valid(sv), .i_sample(smp), .i_events(ev),
        .o_fill_byte_count(lvl), .o_trigger_seen(trg), .o_operating_enable(oen),
        .o_buffer_irq(irq));
    asb_host_model u_host (.i_prdata(prd), .i_ref_clk, .i_pready(rdy), .i_pslverr(err),
        .o_apb(apb));
    task automatic chk(input string n, input logic [15:0] s, x);
        total_checks++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(input logic [7:0] i, d);
        logic [7:0] r;
        logic       e;
        u_host.xfer(1'b1, i, d, r, e);
    endtask
    task automatic rc(input logic [7:0] i, x, input logic xe = 1'b0);
        logic [7:0] r;
        logic       e;
        u_host.xfer(1'b0, i, 8'h00, r, e);
        chk($sformatf("reg %h", i), {r, 7'h0, e}, {x, 7'h0, xe});
    endtask
    // a sample set per pulse, or an event pulse when e is nonzero
    task automatic pulse(input int n, input asb_events_s e);
        repeat (n)
        begin
            @(posedge i_ref_clk);
            sv <= (e == '0);
            ev <= e;
            @(posedge i_ref_clk);
            sv <= 1'b0;
            ev <= '0;
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int i = 'h5e; i < 'h62; i++) rc(8'(i), 8'h00);
        rc(8'h70, 8'h00, 1'b1);
        wr(IDX_DEV_CONTROL, 8'h01);
        rc(IDX_DEV_CONTROL, 8'h01);
        chk("oper enable", 16'(oen), 16'h1);
        wr(IDX_THRESHOLD, 8'h02);
        wr(IDX_OP_CONTROL, 8'h80);
        pulse(3, '0);
        rc(IDX_LEVEL_LOW, 8'd9);
        chk("level pin", 16'(lvl), 16'd9);
        rc(IDX_IRQ_SRC_TWO, 8'h20);
        rc(IDX_READ, 8'ha1);
        rc(IDX_READ, 8'hc3);
        rc(IDX_READ, 8'he5);
        repeat (LEVEL_LAG_CYC) @(posedge i_ref_clk);
        rc(IDX_LEVEL_LOW, 8'd6);
        wr(IDX_CLEAR, 8'h5a);
        rc(IDX_LEVEL_LOW, 8'h00);
        rc(IDX_IRQ_SRC_TWO, 8'h00);
        chk("irq pin", 16'(irq), 16'h0);
        wr(IDX_OP_CONTROL, 8'hc0);
        pulse(88, '0);
        rc(IDX_LEVEL_LOW, CAP_HI_RES[7:0]);
        rc(IDX_LEVEL_HIGH, 8'(CAP_HI_RES[9:8]));
        rc(IDX_IRQ_SRC_TWO, 8'h20);
        wr(IDX_OP_CONTROL, 8'he0);
        pulse(1, '0);
        rc(IDX_IRQ_SRC_TWO, 8'h60);
        rc(IDX_LEVEL_LOW, CAP_HI_RES[7:0]);
        wr(IDX_OP_CONTROL, 8'hc1);
        pulse(2, '0);
        rc(IDX_LEVEL_LOW, CAP_HI_RES[7:0]);
        rc(IDX_IRQ_SRC_TWO, 8'h20);
        wr(IDX_DEV_CONTROL, 8'h00);
        rc(IDX_LEVEL_LOW, 8'h00);
        chk("oper enable", 16'(oen), 16'h0);
        wr(IDX_DEV_CONTROL, 8'h01);
        pulse(2, '0);
        wr(IDX_OP_CONTROL, 8'h40);
        rc(IDX_LEVEL_LOW, 8'h00);
        pulse(2, '0);
        rc(IDX_LEVEL_LOW, 8'h00);
        wr(IDX_OP_CONTROL, 8'h83);
        pulse(1, '0);
        rc(IDX_LEVEL_LOW, 8'h00);
        wr(IDX_OP_CONTROL, 8'h82);
        pulse(5, '0);
        rc(IDX_LEVEL_LOW, 8'd6);
        pulse(1, 6'h01);
        rc(IDX_LEVEL_HIGH, 8'h80);
        chk("trigger pin", 16'(trg), 16'h1);
        pulse(200, '0);
        rc(IDX_LEVEL_LOW, CAP_LO_RES[7:0]);
        rc(IDX_LEVEL_HIGH, 8'h82);
        for (int i = 1; i < 6; i++)
        begin
            wr(IDX_CLEAR, 8'h00);
            rc(IDX_LEVEL_HIGH, 8'h00);
            pulse(1, 6'(1 << i));
            rc(IDX_LEVEL_HIGH, 8'h80);
        end
        give_verdict();
    end
    // hang guard, well past the expected run length
    initial
    begin
        repeat (5000) @(posedge i_ref_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // asb_buffer_ctrl_bench
bind asb_buffer_ctrl asb_buffer_ctrl_asserts #(.DEPTH(DEPTH)) u_ast (.i_ref_clk, .i_rst,
    .i_apb, .i_sample_valid, .i_events, .o_fill_byte_count, .o_trigger_seen,
    .o_operating_enable, .o_buffer_irq);
`default_nettype wire
